// ==== bide_core.sv ====
/*
  Decode and execute core for 12-bit instruction words, with a two-level
  return stack, watchdog counter and shared prescaler, and an AXI4-Lite
  window onto control and state.
  Assumes program memory answers instr_i for pc_o within one core cycle,
  and that ce_i low freezes the bus as well.
*/
`default_nettype none
// Summary of operation
// - One instruction cycle each; PC changes take two cycles.
// - An instruction cycle is four oscillator periods.
// - Byte ops: opcode 11:6, destination bit 5, address 4:0.
// - Bit ops: opcode upper bits, bit number 7:5, address 4:0.
// - Literal ops: opcode 11:8, 8-bit literal 7:0.
// - Jump: opcode 11:9, 9-bit target 8:0.
// - Call pushes PC+1, flags unchanged, two cycles.
// - Call target: literal low, page bits high, bit 8 zero.
// - Register clear writes zero and sets zero flag.
// - Accumulator clear writes zero and sets zero flag.
// - Watchdog clear zeroes counter, prescaler only when assigned.
// - Watchdog clear sets time-out and power-down flags.
// - Every instruction is one 12-bit word.
// - Two-level return stack; call shifts level one to two.
// - Option low nibble selects prescaler owner and ratio.
module bide_core (
  input wire logic core_clk_i,           // Oscillator, 100 MHz
  input wire logic arst_n_i,             // Async reset, active low
  input wire logic ce_i,                 // Clock enable
  input wire logic [11:0] instr_i,       // Word at pc_o
  output logic [10:0] pc_o,              // Fetch address
  output logic cycle_o,                  // Pulse after each cycle
  output logic sleeping_o,               // Core halted
  input wire logic [7:0] s_axi_awaddr_i, // Write address
  input wire logic s_axi_awvalid_i,      // Write address valid
  output logic s_axi_awready_o,          // Write address ready
  input wire logic [31:0] s_axi_wdata_i, // Write data
  input wire logic [3:0] s_axi_wstrb_i,  // Write strobes
  input wire logic s_axi_wvalid_i,       // Write data valid
  output logic s_axi_wready_o,           // Write data ready
  output logic [1:0] s_axi_bresp_o,      // Write response
  output logic s_axi_bvalid_o,           // Write response valid
  input wire logic s_axi_bready_i,       // Write response ready
  input wire logic [7:0] s_axi_araddr_i, // Read address
  input wire logic s_axi_arvalid_i,      // Read address valid
  output logic s_axi_arready_o,          // Read address ready
  output logic [31:0] s_axi_rdata_o,     // Read data
  output logic [1:0] s_axi_rresp_o,      // Read response
  output logic s_axi_rvalid_o,           // Read data valid
  input wire logic s_axi_rready_i        // Read data ready
);
  logic [1:0] phase;
  logic cyc_end;
  logic [11:0] ir;
  logic [10:0] pc;
  logic [10:0] stk1;
  logic [10:0] stk2;
  logic [7:0] w;
  logic [7:0] status;
  logic [7:0] option;
  logic [7:0] wdt;
  logic [7:0] presc;
  logic [7:0] file_q [bide_pkg::NFILE];
  logic asleep;
  logic run;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic w_strb0;
  logic aw_got;
  logic w_got;

  bide_seq u_seq (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .run_i(run && !asleep),
    .phase_o(phase),
    .cyc_end_o(cyc_end)
  );

  // Status is visible at its file address; other addresses hit flops
  function automatic logic [7:0] rd_file(input logic [4:0] a);
    if (a == bide_pkg::STAT_FADDR) begin
      return status;
    end
    return file_q[a];
  endfunction

  // Field extraction, one 12-bit word per instruction
  wire [5:0] op6 = ir[bide_pkg::IW-1:bide_pkg::F_OP6_LO];
  wire dst_f = ir[bide_pkg::F_DST];
  wire [4:0] faddr = ir[bide_pkg::F_ADDR_HI:0];
  wire [2:0] bitsel = ir[bide_pkg::F_BIT_HI:bide_pkg::F_BIT_LO];
  wire [3:0] op4 = ir[bide_pkg::IW-1:bide_pkg::F_OP4_LO];
  wire [7:0] lit8 = ir[bide_pkg::F_LIT_HI:0];
  wire [2:0] op3 = ir[bide_pkg::IW-1:bide_pkg::F_OP3_LO];
  wire [8:0] jmp9 = ir[bide_pkg::F_JMP_HI:0];
  wire [6:0] op7 = ir[bide_pkg::IW-1:bide_pkg::F_OP7_LO];

  wire is_call = (op4 == bide_pkg::OP4_CALL);
  wire is_retlw = (op4 == bide_pkg::OP4_RETLW);
  wire is_movlw = (op4 == bide_pkg::OP4_MOVLW);
  wire is_bcf = (op4 == bide_pkg::OP4_BCF);
  wire is_bsf = (op4 == bide_pkg::OP4_BSF);
  wire is_goto = (op3 == bide_pkg::OP3_GOTO);
  wire is_sub = (op6 == bide_pkg::OP6_SUB);
  wire is_reg_clr = (op7 == bide_pkg::OP7_REG_CLR);
  wire is_acc_clr = (ir == bide_pkg::ENC_ACC_CLR);
  wire is_wdog_clr = (ir == bide_pkg::ENC_WDOG_CLR);
  wire is_sleep = (ir == bide_pkg::ENC_SLEEP);
  wire pc_change = is_call || is_goto || is_retlw;

  wire [7:0] fval = rd_file(faddr);
  // Register minus accumulator as f + ~w + 1; carry out means no borrow
  wire [8:0] sub_sum = {1'b0, fval} + {1'b0, ~w} + 9'h001;
  wire [4:0] sub_lo = {1'b0, fval[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
  wire [7:0] bmask = 8'h01 << bitsel;
  wire [1:0] page = status[bide_pkg::ST_PA_HI:bide_pkg::ST_PA_LO];
  wire [10:0] call_tgt = {page, 1'b0, lit8};
  wire [10:0] next_pc = is_call ? call_tgt :
                        is_goto ? {page, jmp9} :
                        is_retlw ? stk1 : pc + 11'h001;

  // Prescaler owner and ratio
  wire presc_on_wdt = option[bide_pkg::OPT_PRESC_ASSIGN];
  wire [2:0] ps = option[bide_pkg::OPT_PS_HI:0];
  wire [7:0] ps_mask = (8'h01 << ps) - 8'h01;
  wire wdt_tick = !presc_on_wdt || ((presc & ps_mask) == ps_mask);
  wire wdt_clr = is_wdog_clr || is_sleep;
  wire wdt_to = cyc_end && !wdt_clr && wdt_tick && (wdt == 8'hFF);

  // Bus write decode
  wire wr_fire = aw_got && w_got && !s_axi_bvalid_o;
  wire wr_ok = wr_fire && w_strb0;
  wire ctrl_wr = wr_ok && (aw_addr == bide_pkg::REG_CTRL);
  wire stat_wr = wr_ok && (aw_addr == bide_pkg::REG_STAT);
  wire opt_wr = wr_ok && (aw_addr == bide_pkg::REG_OPT);
  wire wake_evt = ctrl_wr && w_data[bide_pkg::CTRL_WAKE];
  wire wr_map = (aw_addr == bide_pkg::REG_CTRL) ||
                (aw_addr == bide_pkg::REG_STAT) ||
                (aw_addr == bide_pkg::REG_OPT);

  // Result steering
  logic file_we;
  logic [7:0] file_wd;
  logic w_we;
  logic [7:0] w_wd;
  logic [7:0] next_status;
  always_comb begin
    file_we = 1'b0;
    file_wd = 8'h00;
    w_we = 1'b0;
    w_wd = 8'h00;
    next_status = status;
    if (stat_wr) begin
      next_status[bide_pkg::ST_PA_HI:bide_pkg::ST_PA_LO] =
        w_data[bide_pkg::ST_PA_HI:bide_pkg::ST_PA_LO];
      next_status[bide_pkg::ST_WAKE] =
        status[bide_pkg::ST_WAKE] && w_data[bide_pkg::ST_WAKE];
    end
    if (cyc_end) begin
      if (is_reg_clr) begin
        file_we = 1'b1;
      end else if (is_sub) begin
        file_we = dst_f;
        file_wd = sub_sum[7:0];
        w_we = !dst_f;
        w_wd = sub_sum[7:0];
      end else if (is_bcf || is_bsf) begin
        file_we = 1'b1;
        file_wd = is_bsf ? (fval | bmask) : (fval & ~bmask);
      end else if (is_acc_clr) begin
        w_we = 1'b1;
      end else if (is_movlw || is_retlw) begin
        w_we = 1'b1;
        w_wd = lit8;
      end
      if (file_we && faddr == bide_pkg::STAT_FADDR) begin
        next_status[bide_pkg::ST_PA_HI:bide_pkg::ST_PA_LO] =
          file_wd[bide_pkg::ST_PA_HI:bide_pkg::ST_PA_LO];
      end
      if (is_reg_clr || is_acc_clr) begin
        next_status[bide_pkg::ST_Z] = 1'b1;
      end
      if (is_sub) begin
        next_status[bide_pkg::ST_C] = sub_sum[8];
        next_status[bide_pkg::ST_DIGIT] = sub_lo[4];
        next_status[bide_pkg::ST_Z] = (sub_sum[7:0] == 8'h00);
      end
      if (wdt_to) begin
        next_status[bide_pkg::ST_TO] = 1'b0;
      end
      if (is_wdog_clr) begin
        next_status[bide_pkg::ST_TO] = 1'b1;
        next_status[bide_pkg::ST_PWRDN] = 1'b1;
      end
      if (is_sleep) begin
        next_status[bide_pkg::ST_TO] = 1'b1;
        next_status[bide_pkg::ST_PWRDN] = 1'b0;
      end
    end
    // Wake event sets the flag even against a software clear
    if (wake_evt) begin
      next_status[bide_pkg::ST_WAKE] = 1'b1;
    end
  end

  // Fetch, pipeline and stack
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc <= bide_pkg::RESET_VEC;
      ir <= bide_pkg::ENC_NOP;
      stk1 <= 11'h000;
      stk2 <= 11'h000;
    end else if (cyc_end) begin
      pc <= next_pc;
      // Discard the word already fetched after a taken jump
      ir <= pc_change ? bide_pkg::ENC_NOP : instr_i;
      if (is_call) begin
        stk2 <= stk1;
        stk1 <= pc;
      end else if (is_retlw) begin
        stk1 <= stk2;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < bide_pkg::NFILE; i++) begin
        file_q[i] <= 8'h00;
      end
    end else if (file_we && faddr != bide_pkg::STAT_FADDR) begin
      file_q[faddr] <= file_wd;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      w <= 8'h00;
      status <= bide_pkg::STATUS_RST;
      option <= bide_pkg::OPTION_RST;
      cycle_o <= 1'b0;
    end else if (ce_i) begin
      if (w_we) begin
        w <= w_wd;
      end
      status <= next_status;
      if (opt_wr) begin
        option <= w_data[7:0];
      end
      cycle_o <= cyc_end;
    end
  end

  // Watchdog and shared prescaler
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdt <= 8'h00;
      presc <= 8'h00;
    end else if (cyc_end) begin
      if (wdt_clr) begin
        wdt <= 8'h00;
        if (presc_on_wdt) begin
          presc <= 8'h00;
        end
      end else begin
        if (presc_on_wdt) begin
          presc <= presc + 8'h01;
        end
        if (wdt_tick) begin
          wdt <= wdt + 8'h01;
        end
      end
    end
  end

  // Sleep halts the sequencer until a wake write
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      asleep <= 1'b0;
      run <= 1'b0;
    end else if (ce_i) begin
      if (wake_evt) begin
        asleep <= 1'b0;
      end else if (cyc_end && is_sleep) begin
        asleep <= 1'b1;
      end
      if (ctrl_wr) begin
        run <= w_data[bide_pkg::CTRL_RUN];
      end
    end
  end

  assign pc_o = pc;
  assign sleeping_o = asleep;

  // AXI4-Lite write channel
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb0 <= 1'b0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= bide_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end else if (!aw_got && !s_axi_bvalid_o) begin
        s_axi_awready_o <= 1'b1;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb0 <= s_axi_wstrb_i[0];
        s_axi_wready_o <= 1'b0;
      end else if (!w_got && !s_axi_bvalid_o) begin
        s_axi_wready_o <= 1'b1;
      end
      if (wr_fire) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_map ? bide_pkg::RESP_OKAY :
                                  bide_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  wire rd_map = (s_axi_araddr_i <= bide_pkg::REG_WDT) &&
                (s_axi_araddr_i[1:0] == 2'h0);
  wire [31:0] rd_word =
    (s_axi_araddr_i == bide_pkg::REG_CTRL) ? {31'h0, run} :
    (s_axi_araddr_i == bide_pkg::REG_STAT) ? {24'h0, status} :
    (s_axi_araddr_i == bide_pkg::REG_ACC) ? {24'h0, w} :
    (s_axi_araddr_i == bide_pkg::REG_OPT) ? {24'h0, option} :
    (s_axi_araddr_i == bide_pkg::REG_PC) ? {5'h0, stk1, 5'h0, pc} :
    (s_axi_araddr_i == bide_pkg::REG_WDT) ? {16'h0, presc, wdt} :
    32'h0000_0000;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= bide_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o <= rd_word;
        s_axi_rresp_o <= rd_map ? bide_pkg::RESP_OKAY :
                                  bide_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end else if (!s_axi_rvalid_o) begin
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  cycle_len_a: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    cyc_end |=> !cyc_end [*3])
    else $error("instruction cycle shorter than four periods");
  jump_flush_a: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (cyc_end && pc_change) |=> (ir == bide_pkg::ENC_NOP) && !cyc_end)
    else $error("fetched word not discarded after jump");
  call_push_a: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (cyc_end && is_call) |=> stk1 == $past(pc) && stk2 == $past(stk1))
    else $error("call did not push the return address");
  call_target_a: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (cyc_end && is_call) |=> pc == {$past(page), 1'b0, $past(lit8)}
      && status[3:0] == $past(status[3:0]))
    else $error("call target or flags wrong");
  clear_zero_a: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (cyc_end && (is_reg_clr || is_acc_clr)) |=> status[bide_pkg::ST_Z])
    else $error("clear did not set zero flag");
  acc_clear_a: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (cyc_end && is_acc_clr) |=> w == 8'h00)
    else $error("accumulator not cleared");
  wdt_clear_a: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (cyc_end && is_wdog_clr) |=> wdt == 8'h00
      && status[bide_pkg::ST_TO] && status[bide_pkg::ST_PWRDN])
    else $error("watchdog clear effects missing");
  sleep_entry_a: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (cyc_end && is_sleep && !wake_evt) |=> asleep && wdt == 8'h00
      && status[bide_pkg::ST_TO] && !status[bide_pkg::ST_PWRDN])
    else $error("sleep entry effects missing");
  sub_carry_a: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    (cyc_end && is_sub) |=>
      status[bide_pkg::ST_C] == ($past(fval) >= $past(w)))
    else $error("subtract carry wrong");
endmodule
`default_nettype wire

// ==== bide_pkg.sv ====
/*
  Constants for the instruction decode and execute block: instruction
  field positions, opcode patterns, status and option bit layout, reset
  values, timing figures and the register window offsets.
  Assumes the core clock is the oscillator itself.
*/
`default_nettype none
package bide_pkg;
  // Oscillator and instruction cycle timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PER_CYCLE = 4;
  localparam int CYCLE_NS = CLK_PERIOD_NS * OSC_PER_CYCLE;
  localparam logic [1:0] PHASE_LAST = 2'h3;

  // Widths
  localparam int IW = 12;
  localparam int PCW = 11;
  localparam int DW = 8;
  localparam int FAW = 5;
  localparam int NFILE = 32;

  // Instruction fields
  localparam int F_OP6_LO = 6;
  localparam int F_DST = 5;
  localparam int F_ADDR_HI = 4;
  localparam int F_BIT_HI = 7;
  localparam int F_BIT_LO = 5;
  localparam int F_OP4_LO = 8;
  localparam int F_LIT_HI = 7;
  localparam int F_OP3_LO = 9;
  localparam int F_JMP_HI = 8;
  localparam int F_OP7_LO = 5;

  // Opcode patterns
  localparam logic [3:0] OP4_CALL = 4'h9;
  localparam logic [3:0] OP4_RETLW = 4'h8;
  localparam logic [3:0] OP4_MOVLW = 4'hC;
  localparam logic [3:0] OP4_BCF = 4'h4;
  localparam logic [3:0] OP4_BSF = 4'h5;
  localparam logic [2:0] OP3_GOTO = 3'h5;
  localparam logic [5:0] OP6_SUB = 6'h02;
  localparam logic [6:0] OP7_REG_CLR = 7'h03;
  localparam logic [11:0] ENC_ACC_CLR = 12'h040;
  localparam logic [11:0] ENC_WDOG_CLR = 12'h004;
  localparam logic [11:0] ENC_SLEEP = 12'h003;
  localparam logic [11:0] ENC_NOP = 12'h000;

  // Status register layout
  localparam logic [4:0] STAT_FADDR = 5'h03;
  localparam int ST_C = 0;
  localparam int ST_DIGIT = 1;
  localparam int ST_Z = 2;
  localparam int ST_PWRDN = 3;
  localparam int ST_TO = 4;
  localparam int ST_PA_LO = 5;
  localparam int ST_PA_HI = 6;
  localparam int ST_WAKE = 7;
  localparam logic [7:0] STATUS_RST = 8'h18;

  // Option register layout
  localparam int OPT_PRESC_ASSIGN = 3;
  localparam int OPT_PS_HI = 2;
  localparam logic [7:0] OPTION_RST = 8'hFF;

  localparam logic [10:0] RESET_VEC = 11'h000;

  // Register window
  localparam int AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_OPT = 8'h0C;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_WDT = 8'h14;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WAKE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== bide_seq.sv ====
/*
  Phase sequencer: splits the oscillator into instruction cycles of four
  periods and marks the last period of each cycle.
  Assumes run_i is steady from the core clock domain.
*/
`default_nettype none
module bide_seq (
  input wire logic core_clk_i,  // Oscillator
  input wire logic arst_n_i,    // Async reset, active low
  input wire logic ce_i,        // Clock enable
  input wire logic run_i,       // Oscillator running
  output logic [1:0] phase_o,   // Current quarter of the cycle
  output logic cyc_end_o        // Last quarter, combinational
);
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_o <= 2'h0;
    end else if (ce_i && run_i) begin
      phase_o <= phase_o + 2'h1;
    end
  end

  assign cyc_end_o = ce_i && run_i && (phase_o == bide_pkg::PHASE_LAST);
endmodule
`default_nettype wire

// ==== bide_rom.sv ====
/*
  Program memory model: a small combinational ROM of 12-bit words.
  Assumes the core reads it at its cycle-end edge, as a plain ROM.
*/
`default_nettype none
module bide_rom (
  input wire logic [10:0] addr_i, // Fetch address
  output logic [11:0] data_o      // Word at addr_i
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    case (addr_i)
      11'h000: data_o = 12'h040; // Accumulator clear
      11'h001: data_o = 12'hC5A; // Load 0x5A
      11'h002: data_o = 12'h090; // Reg 0x10 minus acc into acc
      11'h003: data_o = 12'h071; // Clear reg 0x11
      11'h004: data_o = 12'h004; // Watchdog clear
      11'h005: data_o = 12'h940; // Call 0x40
      11'h006: data_o = 12'hA50; // Jump 0x050 on the current page
      11'h040: data_o = 12'h003; // Sleep
      11'h042: data_o = 12'h5A3; // Set status bit 5, page 1
      11'h043: data_o = 12'h833; // Return with 0x33
      11'h250: data_o = 12'h4A3; // Clear status bit 5, page 0
      11'h251: data_o = 12'h003; // Sleep again
      default: data_o = 12'h000; // Empty space runs as no-op
    endcase
  end
endmodule
`default_nettype wire

// ==== baseline_instruction_decode_exec_tb.sv ====
/*
  Testbench: drives the register bus, runs a short program, checks state.
  Assumes the core and the ROM model sit on one 100 MHz clock.
*/
`default_nettype none
module baseline_instruction_decode_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, arst_n = 1'b0;
  logic [11:0] instr;
  logic [10:0] pc;
  logic cyc, slp, awr, wr_rdy, bv, arr, rv;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd_o, rdat;
  logic [3:0] ws = 4'h0;
  logic awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic ce = 1'b1;
  logic [1:0] bresp, rresp, rsp;
  int checks = 0, bad_count = 0, cnt = 0, n;
  bide_core i_dut (.core_clk_i(clk), .arst_n_i(arst_n), .ce_i(ce),
    .instr_i(instr), .pc_o(pc), .cycle_o(cyc), .sleeping_o(slp),
    .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv),
    .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
    .s_axi_bready_i(brd), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
    .s_axi_arready_o(arr), .s_axi_rdata_o(rd_o), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rv), .s_axi_rready_i(rrd));
  bide_rom i_rom (.addr_i(pc), .data_o(instr));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic results;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Hang guard: the whole program fits well inside this
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (cnt == 20000) begin
      bad_count++;
      results();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Both channels offered together, each released when taken
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    rsp = bresp;
    brd <= 1'b0;
    // Idle edge: a following call must not drive bready in the same step
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rdat = rd_o;
    rsp = rresp;
    rrd <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(bide_pkg::REG_STAT);
    chk("status reset", rdat, 32'h18);
    rd(bide_pkg::REG_OPT);
    chk("option reset", rdat, 32'hFF);
    rd(8'h20);
    chk("unmapped rresp", 32'(rsp), 32'h2);
    wr(8'h20, 32'h1, 4'hF);
    chk("unmapped bresp", 32'(rsp), 32'h2);
    wr(bide_pkg::REG_OPT, 32'h07, 4'h0);
    rd(bide_pkg::REG_OPT);
    chk("option no strobe", rdat, 32'hFF);
    // Keep the prescaler on the watchdog, ratio 1:128
    wr(bide_pkg::REG_OPT, 32'h0F, 4'hF);
    rd(bide_pkg::REG_OPT);
    chk("option write", rdat, 32'h0F);
    wr(bide_pkg::REG_CTRL, 32'h1, 4'hF);
    n = 0;
    while (!cyc && n < 100) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!cyc && n < 100);
    chk("cycle length", 32'(n), 32'(bide_pkg::OSC_PER_CYCLE));
    n = 0;
    while (!slp && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("sleeping", 32'(slp), 32'h1);
    chk("pc page", 32'(pc[10:6]), 32'h1);
    rd(bide_pkg::REG_STAT);
    chk("status after sleep", rdat, 32'h14);
    rd(bide_pkg::REG_ACC);
    chk("acc difference", rdat, 32'hA6);
    rd(bide_pkg::REG_PC);
    chk("return level one", 32'(rdat[26:16]), 32'h6);
    rd(bide_pkg::REG_WDT);
    chk("wdt and prescaler", 32'(rdat[15:0]), 32'h0);
    repeat (20) @(posedge clk);
    rd(bide_pkg::REG_WDT);
    chk("halted wdt", 32'(rdat[15:0]), 32'h0);
    wr(bide_pkg::REG_CTRL, 32'h3, 4'hF);
    repeat (2) @(posedge clk);
    chk("woken", 32'(slp), 32'h0);
    rd(bide_pkg::REG_STAT);
    chk("wake flag", 32'(rdat[7]), 32'h1);
    // Freeze mid-run: pc must hold while the enable is low
    ce <= 1'b0;
    @(posedge clk);
    n = pc;
    repeat (8) @(posedge clk);
    chk("frozen pc", 32'(pc), 32'(n));
    ce <= 1'b1;
    n = 0;
    while (!slp && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("second sleep", 32'(slp), 32'h1);
    rd(bide_pkg::REG_PC);
    chk("jump target and pop", rdat, 32'h253);
    rd(bide_pkg::REG_ACC);
    chk("return literal", rdat, 32'h33);
    rd(bide_pkg::REG_STAT);
    chk("bit set and clear", rdat, 32'h94);
    results();
  end
endmodule
`default_nettype wire
